// [rtl/dlct_prescale.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dlct_consts.svh"
module dlct_prescale (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_rise,
  input wire dlct_pkg::dlct_prescale_t prescale_field,
  output logic pre_tick,
  output logic div12_tick,
  output logic ext8_tick
);
  import dlct_pkg::*;

  logic [1:0] c4_q, c4_d;
  logic [3:0] c12_q, c12_d;
  logic [5:0] c48_q, c48_d;
  logic [2:0] c8_q, c8_d;
  logic div4_tick;
  logic div48_tick;

  assign div4_tick = (c4_q == `DLCT_DIV4_LAST);
  assign div12_tick = (c12_q == `DLCT_DIV12_LAST);
  assign div48_tick = (c48_q == `DLCT_DIV48_LAST);
  // ext edges already synchronised, so this tick lives in the system domain
  assign ext8_tick = ext_rise & (c8_q == `DLCT_DIV8_LAST);

  always_comb begin
    c4_d = div4_tick ? 2'h0 : c4_q + 2'h1;
    c12_d = div12_tick ? 4'h0 : c12_q + 4'h1;
    c48_d = div48_tick ? 6'h00 : c48_q + 6'h01;
    c8_d = ext_rise ? c8_q + 3'h1 : c8_q;
    unique case (prescale_field)
      DLCT_PRE_DIV12: pre_tick = div12_tick;
      DLCT_PRE_DIV4: pre_tick = div4_tick;
      DLCT_PRE_DIV48: pre_tick = div48_tick;
      DLCT_PRE_EXT8: pre_tick = ext8_tick;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c4_q <= 2'h0;
      c12_q <= 4'h0;
      c48_q <= 6'h00;
      c8_q <= 3'h0;
    end else begin
      c4_q <= c4_d;
      c12_q <= c12_d;
      c48_q <= c48_d;
      c8_q <= c8_d;
    end
  end
endmodule // dlct_prescale
`default_nettype wire

// [rtl/dlct_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module dlct_sync_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fall,
  output logic rise
);
  import dlct_pkg::*;

  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= sh_d;
    end
  end

  // stage 0 feeds only stage 1
  assign level = sh_q[1];
  assign fall = sh_q[2] & ~sh_q[1];
  assign rise = ~sh_q[2] & sh_q[1];
endmodule // dlct_sync_edge
`default_nettype wire

// [rtl/dlct_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dlct_consts.svh"
// Behaviour
// - timer A counts when run and gate allow
// - run bit never clears or preloads counts
// - timer B mirrors A with own controls
// - mode 1 is a full 16-bit counter
// - mode 2 reloads low from high, flags
// - set overflow flag raises enabled interrupt
// - split mode: A low byte, A controls
// - split mode: A high byte, B run/flag
// - B runs unflagged, timer-only, pulse still out
// - B in mode 3 is stopped
// - two-bit mode fields at bits 1-0, 5-4
// - counter select counts pin falling edges
// - gate bits 7 and 3 need gate input
// - clock select: system or prescaled clock
// - prescale field picks 12, 4, 48, ext/8
// - external divided clock synchronised first
// - high-byte selects used only in split mode
// - low-byte selects pick system or ext-select clock
// - B overflow flag at control bit 7
// - mode 0 counts high byte plus five bits
module dlct_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic gate_a_polarity,
  input wire logic gate_b_polarity,
  input wire logic ext_osc_clk,
  input wire logic tmr_a_irq_enable,
  input wire logic tmr_b_irq_enable,
  input wire logic tmr_a_irq_ack,
  input wire logic tmr_b_irq_ack,
  input wire logic tmr_c_ext_clk_select,
  input wire logic tmr_c_split,
  input wire logic tmr_d_ext_clk_select,
  input wire logic tmr_d_split,
  output logic tmr_a_irq,
  output logic tmr_b_irq,
  output logic tmr_a_overflow_pulse,
  output logic tmr_b_overflow_pulse,
  output logic tmr_c_low_tick,
  output logic tmr_c_high_tick,
  output logic tmr_d_low_tick,
  output logic tmr_d_high_tick
);
  import dlct_pkg::*;

  // one count step for modes 0-2; bit 16 is the overflow
  function automatic logic [16:0] dlct_step(
    input dlct_mode_t mode,
    input logic [7:0] th,
    input logic [7:0] tl
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h0_0001;
    s8 = {1'b0, tl} + 9'h001;
    unique case (mode)
      // upper low-byte bits are left alone in 13-bit mode
      DLCT_MODE_13BIT: dlct_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
      DLCT_MODE_16BIT: dlct_step = s16;
      DLCT_MODE_RELOAD: dlct_step = s8[8] ? {1'b1, th, th} : {1'b0, th, s8[7:0]};
      DLCT_MODE_SPLIT: dlct_step = {1'b0, th, tl};
    endcase
  endfunction

  // clock enable of a timer: pin edge, system clock or prescaler
  function automatic logic dlct_src(
    input logic count_sel,
    input logic sys_sel,
    input logic pin_fall,
    input logic pre
  );
    dlct_src = count_sel ? pin_fall : (sys_sel | pre);
  endfunction

  function automatic logic dlct_gate_ok(
    input logic gate_en,
    input logic level,
    input logic polarity
  );
    dlct_gate_ok = ~gate_en | (level == polarity);
  endfunction

  logic [7:0] ctl_q, ctl_d;
  logic [7:0] mod_q, mod_d;
  logic [7:0] cks_q, cks_d;
  logic [7:0] a_lo_q, a_lo_d;
  logic [7:0] a_hi_q, a_hi_d;
  logic [7:0] b_lo_q, b_lo_d;
  logic [7:0] b_hi_q, b_hi_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_a_q, irq_a_d;
  logic irq_b_q, irq_b_d;
  logic ovp_a_q, ovp_a_d;
  logic ovp_b_q, ovp_b_d;
  logic [3:0] ctk_q, ctk_d;

  logic [4:0] pins;
  logic [4:0] pin_level;
  logic [4:0] pin_fall;
  logic [4:0] pin_rise;
  logic pre_tick;
  logic div12_tick;
  logic ext8_tick;

  dlct_mode_t mode_a;
  dlct_mode_t mode_b;
  logic split_a;
  logic run_a_ok;
  logic run_b_ok;
  logic tick_a;
  logic tick_b;
  logic tick_a_timer;
  logic tick_b_timer;
  logic inc_a;
  logic inc_a_hi;
  logic inc_b;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic ovf_a;
  logic ovf_a_hi;
  logic ovf_b;
  logic set_a_flag;
  logic set_b_flag;
  logic c_src;
  logic d_src;

  assign pins = {ext_osc_clk, gate_input_b, gate_input_a, event_pin_b, event_pin_a};

  // every pin gets its own two-stage synchroniser
  for (genvar i = 0; i < 5; i++) begin : g_sync
    dlct_sync_edge u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(pins[i]),
      .level(pin_level[i]),
      .fall(pin_fall[i]),
      .rise(pin_rise[i])
    );
  end

  dlct_prescale u_pre (
    .sys_clk(sys_clk),
    .rst(rst),
    .ext_rise(pin_rise[4]),
    .prescale_field(dlct_prescale_t'(cks_q[`DLCT_CKS_PRE_HI:`DLCT_CKS_PRE_LO])),
    .pre_tick(pre_tick),
    .div12_tick(div12_tick),
    .ext8_tick(ext8_tick)
  );

  assign mode_a = dlct_mode_t'(mod_q[`DLCT_MOD_A_MODE_HI:`DLCT_MOD_A_MODE_LO]);
  assign mode_b = dlct_mode_t'(mod_q[`DLCT_MOD_B_MODE_HI:`DLCT_MOD_B_MODE_LO]);
  assign split_a = (mode_a == DLCT_MODE_SPLIT);

  assign run_a_ok = ctl_q[`DLCT_CTL_A_RUN]
    & dlct_gate_ok(mod_q[`DLCT_MOD_A_GATE], pin_level[2], gate_a_polarity);
  assign run_b_ok = ctl_q[`DLCT_CTL_B_RUN]
    & dlct_gate_ok(mod_q[`DLCT_MOD_B_GATE], pin_level[3], gate_b_polarity);

  // pin events bypass the clock select bit, which only matters in timer mode
  assign tick_a = dlct_src(mod_q[`DLCT_MOD_A_COUNT], cks_q[`DLCT_CKS_A_SYS],
    pin_fall[0], pre_tick);
  assign tick_b = dlct_src(mod_q[`DLCT_MOD_B_COUNT], cks_q[`DLCT_CKS_B_SYS],
    pin_fall[1], pre_tick);
  assign tick_a_timer = dlct_src(1'b0, cks_q[`DLCT_CKS_A_SYS], 1'b0, pre_tick);
  assign tick_b_timer = dlct_src(1'b0, cks_q[`DLCT_CKS_B_SYS], 1'b0, pre_tick);

  assign inc_a = run_a_ok & tick_a;
  // split high byte: timer only, run by B's run bit, no gate
  assign inc_a_hi = split_a & ctl_q[`DLCT_CTL_B_RUN] & tick_a_timer;
  // with A split, B runs by mode alone and never counts pin events
  assign inc_b = (mode_b != DLCT_MODE_SPLIT)
    & (split_a ? tick_b_timer : (run_b_ok & tick_b));

  assign step_a = dlct_step(mode_a, a_hi_q, a_lo_q);
  assign step_b = dlct_step(mode_b, b_hi_q, b_lo_q);
  assign ovf_a = inc_a & (split_a ? (a_lo_q == 8'hFF) : step_a[16]);
  assign ovf_a_hi = inc_a_hi & (a_hi_q == 8'hFF);
  assign ovf_b = inc_b & step_b[16];
  assign set_a_flag = ovf_a;
  assign set_b_flag = split_a ? ovf_a_hi : ovf_b;

  assign c_src = tmr_c_ext_clk_select ? ext8_tick : div12_tick;
  assign d_src = tmr_d_ext_clk_select ? ext8_tick : div12_tick;

  always_comb begin
    ctl_d = ctl_q;
    mod_d = mod_q;
    cks_d = cks_q;
    a_lo_d = a_lo_q;
    a_hi_d = a_hi_q;
    b_lo_d = b_lo_q;
    b_hi_d = b_hi_q;
    rdata_d = 8'h00;

    // counting resumes from the held value; nothing is preloaded
    if (split_a) begin
      if (inc_a) begin
        a_lo_d = a_lo_q + 8'h01;
      end
      if (inc_a_hi) begin
        a_hi_d = a_hi_q + 8'h01;
      end
    end else if (inc_a) begin
      {a_hi_d, a_lo_d} = step_a[15:0];
    end
    if (inc_b) begin
      {b_hi_d, b_lo_d} = step_b[15:0];
    end

    // a software write beats the count in the same cycle
    if (sfr_wr) begin
      unique case (sfr_addr)
        `DLCT_ADDR_CONTROL: ctl_d = sfr_wdata;
        `DLCT_ADDR_MODE: mod_d = sfr_wdata;
        `DLCT_ADDR_CLK_SEL: cks_d = sfr_wdata;
        `DLCT_ADDR_A_LOW: a_lo_d = sfr_wdata;
        `DLCT_ADDR_A_HIGH: a_hi_d = sfr_wdata;
        `DLCT_ADDR_B_LOW: b_lo_d = sfr_wdata;
        `DLCT_ADDR_B_HIGH: b_hi_d = sfr_wdata;
        default: ctl_d = ctl_q;
      endcase
    end

    // acknowledge clears, but a hardware set in that cycle wins
    if (tmr_a_irq_ack) begin
      ctl_d[`DLCT_CTL_A_OVF] = 1'b0;
    end
    if (tmr_b_irq_ack) begin
      ctl_d[`DLCT_CTL_B_OVF] = 1'b0;
    end
    if (set_a_flag) begin
      ctl_d[`DLCT_CTL_A_OVF] = 1'b1;
    end
    if (set_b_flag) begin
      ctl_d[`DLCT_CTL_B_OVF] = 1'b1;
    end

    if (sfr_rd) begin
      unique case (sfr_addr)
        `DLCT_ADDR_CONTROL: rdata_d = ctl_q;
        `DLCT_ADDR_MODE: rdata_d = mod_q;
        `DLCT_ADDR_CLK_SEL: rdata_d = cks_q;
        `DLCT_ADDR_A_LOW: rdata_d = a_lo_q;
        `DLCT_ADDR_A_HIGH: rdata_d = a_hi_q;
        `DLCT_ADDR_B_LOW: rdata_d = b_lo_q;
        `DLCT_ADDR_B_HIGH: rdata_d = b_hi_q;
        default: rdata_d = 8'h00;
      endcase
    end

    irq_a_d = ctl_d[`DLCT_CTL_A_OVF] & tmr_a_irq_enable;
    irq_b_d = ctl_d[`DLCT_CTL_B_OVF] & tmr_b_irq_enable;
    ovp_a_d = ovf_a;
    // pulse stays for baud and converter users even when the flag is blocked
    ovp_b_d = ovf_b;

    // low select picks the whole timer clock; high select only when split
    ctk_d[0] = cks_q[`DLCT_CKS_C_LOW] | c_src;
    ctk_d[1] = tmr_c_split ? (cks_q[`DLCT_CKS_C_HIGH] | c_src) : ctk_d[0];
    ctk_d[2] = cks_q[`DLCT_CKS_D_LOW] | d_src;
    ctk_d[3] = tmr_d_split ? (cks_q[`DLCT_CKS_D_HIGH] | d_src) : ctk_d[2];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= `DLCT_RST_BYTE;
      mod_q <= `DLCT_RST_BYTE;
      cks_q <= `DLCT_RST_BYTE;
      a_lo_q <= `DLCT_RST_BYTE;
      a_hi_q <= `DLCT_RST_BYTE;
      b_lo_q <= `DLCT_RST_BYTE;
      b_hi_q <= `DLCT_RST_BYTE;
      rdata_q <= `DLCT_RST_BYTE;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      ovp_a_q <= 1'b0;
      ovp_b_q <= 1'b0;
      ctk_q <= 4'h0;
    end else begin
      ctl_q <= ctl_d;
      mod_q <= mod_d;
      cks_q <= cks_d;
      a_lo_q <= a_lo_d;
      a_hi_q <= a_hi_d;
      b_lo_q <= b_lo_d;
      b_hi_q <= b_hi_d;
      rdata_q <= rdata_d;
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      ovp_a_q <= ovp_a_d;
      ovp_b_q <= ovp_b_d;
      ctk_q <= ctk_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign tmr_a_irq = irq_a_q;
  assign tmr_b_irq = irq_b_q;
  assign tmr_a_overflow_pulse = ovp_a_q;
  assign tmr_b_overflow_pulse = ovp_b_q;
  assign tmr_c_low_tick = ctk_q[0];
  assign tmr_c_high_tick = ctk_q[1];
  assign tmr_d_low_tick = ctk_q[2];
  assign tmr_d_high_tick = ctk_q[3];
endmodule // dlct_top
`default_nettype wire

// [shared/dlct_consts.svh]
`ifndef DLCT_CONSTS_SVH
`define DLCT_CONSTS_SVH

// register addresses on the special function register port
`define DLCT_ADDR_CONTROL 8'h88
`define DLCT_ADDR_MODE 8'h89
`define DLCT_ADDR_A_LOW 8'h8A
`define DLCT_ADDR_B_LOW 8'h8B
`define DLCT_ADDR_A_HIGH 8'h8C
`define DLCT_ADDR_B_HIGH 8'h8D
`define DLCT_ADDR_CLK_SEL 8'h8E

// reset values
`define DLCT_RST_BYTE 8'h00

// timer_control fields
`define DLCT_CTL_B_OVF 7
`define DLCT_CTL_B_RUN 6
`define DLCT_CTL_A_OVF 5
`define DLCT_CTL_A_RUN 4

// timer_mode fields
`define DLCT_MOD_B_GATE 7
`define DLCT_MOD_B_COUNT 6
`define DLCT_MOD_B_MODE_HI 5
`define DLCT_MOD_B_MODE_LO 4
`define DLCT_MOD_A_GATE 3
`define DLCT_MOD_A_COUNT 2
`define DLCT_MOD_A_MODE_HI 1
`define DLCT_MOD_A_MODE_LO 0

// timer_clock_select fields
`define DLCT_CKS_D_HIGH 7
`define DLCT_CKS_D_LOW 6
`define DLCT_CKS_C_HIGH 5
`define DLCT_CKS_C_LOW 4
`define DLCT_CKS_B_SYS 3
`define DLCT_CKS_A_SYS 2
`define DLCT_CKS_PRE_HI 1
`define DLCT_CKS_PRE_LO 0

// divider terminal counts (divide ratio minus one)
`define DLCT_DIV4_LAST 2'h3
`define DLCT_DIV12_LAST 4'hB
`define DLCT_DIV48_LAST 6'h2F
`define DLCT_DIV8_LAST 3'h7

`endif

// [shared/dlct_pkg.sv]
package dlct_pkg;

  typedef enum logic [1:0] {
    DLCT_MODE_13BIT = 2'h0,
    DLCT_MODE_16BIT = 2'h1,
    DLCT_MODE_RELOAD = 2'h2,
    DLCT_MODE_SPLIT = 2'h3
  } dlct_mode_t;

  typedef enum logic [1:0] {
    DLCT_PRE_DIV12 = 2'h0,
    DLCT_PRE_DIV4 = 2'h1,
    DLCT_PRE_DIV48 = 2'h2,
    DLCT_PRE_EXT8 = 2'h3
  } dlct_prescale_t;

endpackage

// [test/dlct_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dlct_pins_model (
  input wire logic sys_clk,
  input wire logic ev_on_a,
  input wire logic ev_on_b,
  input wire logic gate_lvl_a,
  input wire logic gate_lvl_b,
  output logic event_pin_a,
  output logic event_pin_b,
  output logic gate_input_a,
  output logic gate_input_b,
  output logic ext_osc_clk
);
  logic [1:0] phase = 2'h0;
  initial begin
    event_pin_a = 1'b1;
    event_pin_b = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
    ext_osc_clk = 1'b0;
  end
  // a pin only rises with phase, so no high level is ever shorter than two clocks
  always @(negedge sys_clk) begin
    phase <= phase + 2'h1;
    event_pin_a <= phase[1] | (!ev_on_a && event_pin_a);
    event_pin_b <= phase[1] | (!ev_on_b && event_pin_b);
    gate_input_a <= gate_lvl_a;
    gate_input_b <= gate_lvl_b;
    ext_osc_clk <= phase[1];
  end
endmodule // dlct_pins_model
`default_nettype wire

// [test/dlct_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dlct_consts.svh"
module dlct_top_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic tmr_a_irq_enable,
  input wire logic tmr_a_irq_ack,
  input wire logic tmr_c_split,
  input wire logic tmr_a_irq,
  input wire logic tmr_a_overflow_pulse,
  input wire logic tmr_b_overflow_pulse,
  input wire logic tmr_c_low_tick,
  input wire logic tmr_c_high_tick
);
  logic [7:0] ctl_q;
  logic [7:0] mode_q;
  logic [7:0] cks_q;
  logic ctl_wr;
  assign ctl_wr = sfr_wr && sfr_addr == `DLCT_ADDR_CONTROL;
  // software bits only; hardware flags are not shadowed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= 8'h00;
      mode_q <= 8'h00;
      cks_q <= 8'h00;
    end else begin
      if (ctl_wr) ctl_q <= sfr_wdata;
      if (sfr_wr && sfr_addr == `DLCT_ADDR_MODE) mode_q <= sfr_wdata;
      if (sfr_wr && sfr_addr == `DLCT_ADDR_CLK_SEL) cks_q <= sfr_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence mode_wr_s; sfr_wr && sfr_addr == `DLCT_ADDR_MODE; endsequence
  sequence mode_rd_s; sfr_rd && !sfr_wr && sfr_addr == `DLCT_ADDR_MODE; endsequence
  mode_readback_a: assert property (mode_wr_s ##1 mode_rd_s |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode readback wrong");
  rdata_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  a_irq_mask_a: assert property (!tmr_a_irq_enable |=> !tmr_a_irq)
    else $error("masked irq raised");
  irq_on_pulse_a: assert property (tmr_a_overflow_pulse && $past(tmr_a_irq_enable) |-> tmr_a_irq)
    else $error("irq missing on overflow");
  // a clear seen at this edge already drops the level one cycle later
  irq_hold_a: assert property (tmr_a_irq && tmr_a_irq_enable && !tmr_a_irq_ack && !ctl_wr |=> tmr_a_irq)
    else $error("irq dropped early");
  a_stopped_a: assert property (!$past(ctl_q[`DLCT_CTL_A_RUN]) |-> !tmr_a_overflow_pulse)
    else $error("stopped timer overflowed");
  b_inactive_a: assert property ($past(mode_q[5:4]) == 2'h3 && $past(mode_q[1:0]) != 2'h3
    |-> !tmr_b_overflow_pulse)
    else $error("inactive timer overflowed");
  c_low_sys_a: assert property ($past(cks_q[`DLCT_CKS_C_LOW]) |-> tmr_c_low_tick)
    else $error("low tick missing");
  c_high_tie_a: assert property (!$past(tmr_c_split) |-> tmr_c_high_tick == tmr_c_low_tick)
    else $error("high tick differs");
endmodule // dlct_top_properties
bind dlct_top dlct_top_properties u_props (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .tmr_a_irq_enable(tmr_a_irq_enable), .tmr_a_irq_ack(tmr_a_irq_ack), .tmr_c_split(tmr_c_split),
  .tmr_a_irq(tmr_a_irq), .tmr_a_overflow_pulse(tmr_a_overflow_pulse),
  .tmr_b_overflow_pulse(tmr_b_overflow_pulse), .tmr_c_low_tick(tmr_c_low_tick),
  .tmr_c_high_tick(tmr_c_high_tick));
`default_nettype wire

// [test/dual_legacy_counter_timers_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dlct_consts.svh"
module dual_legacy_counter_timers_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic pin_a, pin_b, gin_a, gin_b, osc;
  logic pol_a = 1'b1;
  logic a_ie = 1'b0;
  logic b_ie = 1'b0;
  logic a_ack = 1'b0;
  logic c_ext = 1'b0;
  logic d_ext = 1'b1;
  logic c_split = 1'b0;
  logic d_split = 1'b0;
  logic ev_a = 1'b0;
  logic ev_b = 1'b0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic b_ack = 1'b0;
  // each bit has its own output pin as driver, so a net
  wire [7:0] obs;
  int mismatches = 0;
  int checks = 0;

  dlct_top dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .event_pin_a(pin_a), .event_pin_b(pin_b),
    .gate_input_a(gin_a), .gate_input_b(gin_b), .gate_a_polarity(pol_a), .gate_b_polarity(1'b1),
    .ext_osc_clk(osc), .tmr_a_irq_enable(a_ie), .tmr_b_irq_enable(b_ie), .tmr_a_irq_ack(a_ack),
    .tmr_b_irq_ack(b_ack), .tmr_c_ext_clk_select(c_ext), .tmr_c_split(c_split),
    .tmr_d_ext_clk_select(d_ext), .tmr_d_split(d_split), .tmr_a_irq(obs[0]), .tmr_b_irq(obs[1]),
    .tmr_a_overflow_pulse(obs[2]), .tmr_b_overflow_pulse(obs[3]), .tmr_c_low_tick(obs[4]),
    .tmr_c_high_tick(obs[5]), .tmr_d_low_tick(obs[6]), .tmr_d_high_tick(obs[7]));
  dlct_pins_model u_pins (.sys_clk(sys_clk), .ev_on_a(ev_a), .ev_on_b(ev_b), .gate_lvl_a(lvl_a),
    .gate_lvl_b(lvl_b), .event_pin_a(pin_a), .event_pin_b(pin_b), .gate_input_a(gin_a),
    .gate_input_b(gin_b), .ext_osc_clk(osc));

  always #12.5 sys_clk = !sys_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(negedge sys_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    chk(what, sfr_rdata & mask, exp);
  endtask
  task automatic prep(input logic b, input logic [7:0] m, c, h, l, ctl);
    wr(`DLCT_ADDR_MODE, m);
    wr(`DLCT_ADDR_CLK_SEL, c);
    wr(b ? `DLCT_ADDR_B_HIGH : `DLCT_ADDR_A_HIGH, h);
    wr(b ? `DLCT_ADDR_B_LOW : `DLCT_ADDR_A_LOW, l);
    wr(`DLCT_ADDR_CONTROL, ctl);
  endtask
  task automatic watch(input int sel, input int lim, output int first, output int last, output int hits);
    first = 0;
    last = 0;
    hits = 0;
    for (int i = 1; i <= lim; i++) begin
      @(negedge sys_clk);
      if (obs[sel] === 1'b1) begin
        if (hits == 0) first = i;
        last = i;
        hits++;
      end
    end
  endtask

  task automatic t_regs;
    rdchk("mode reset", `DLCT_ADDR_MODE, 8'hFF, 8'h00);
    rdchk("a low reset", `DLCT_ADDR_A_LOW, 8'hFF, 8'h00);
    rdchk("clk sel reset", `DLCT_ADDR_CLK_SEL, 8'hFF, 8'h00);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = `DLCT_ADDR_MODE;
    sfr_wdata = 8'hA5;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
    // read right behind the write, so the readback property is exercised
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    chk("mode readback", sfr_rdata, 8'hA5);
    wr(8'h80, 8'h5A);
    rdchk("unmapped read", 8'h80, 8'hFF, 8'h00);
  endtask
  task automatic t_wrap;
    int f, l, h;
    a_ie = 1'b1;
    for (int m = 0; m < 2; m++) begin
      // 16 counts to wrap in both widths; a cleared count would take thousands
      prep(1'b0, m[7:0], 8'h04, 8'hFF, 8'hF0, 8'h10);
      watch(2, 40, f, l, h);
      chk("single wrap", h, 1);
      chk("wrap time", f >= 15 && f <= 19, 1);
      chk("irq held", obs[0], 1'b1);
      a_ack = 1'b1;
      @(negedge sys_clk);
      a_ack = 1'b0;
      @(negedge sys_clk);
      chk("irq acked", obs[0], 1'b0);
      wr(`DLCT_ADDR_CONTROL, 8'h00);
      rdchk("high after wrap", `DLCT_ADDR_A_HIGH, 8'hFF, 8'h00);
      rdchk("low upper kept", `DLCT_ADDR_A_LOW, m ? 8'h00 : 8'hE0, m ? 8'h00 : 8'hE0);
    end
    a_ie = 1'b0;
  endtask
  task automatic t_reload;
    int f, l, h;
    prep(1'b0, 8'h02, 8'h04, 8'hF0, 8'hFE, 8'h10);
    watch(2, 60, f, l, h);
    chk("reload period", l - f, (h - 1) * 16);
    chk("reload count", h >= 3, 1);
    wr(`DLCT_ADDR_CONTROL, 8'h00);
    rdchk("reload kept", `DLCT_ADDR_A_HIGH, 8'hFF, 8'hF0);
  endtask
  task automatic t_gate;
    int f, l, h;
    prep(1'b0, 8'h0A, 8'h04, 8'hF0, 8'hFE, 8'h10);
    watch(2, 40, f, l, h);
    chk("gate closed", h, 0);
    lvl_a <= 1'b1;
    watch(2, 40, f, l, h);
    chk("gate open", h != 0, 1);
    pol_a = 1'b0;
    watch(2, 8, f, l, h);
    watch(2, 40, f, l, h);
    chk("gate inverted", h, 0);
    prep(1'b0, 8'h02, 8'h04, 8'hF0, 8'hFE, 8'h00);
    watch(2, 40, f, l, h);
    chk("run off", h, 0);
    prep(1'b1, 8'hA0, 8'h08, 8'hF0, 8'hFE, 8'h40);
    watch(3, 40, f, l, h);
    chk("b gate closed", h, 0);
    lvl_b <= 1'b1;
    watch(3, 40, f, l, h);
    chk("b gate open", h != 0, 1);
    wr(`DLCT_ADDR_CONTROL, 8'h00);
    lvl_b <= 1'b0;
    lvl_a <= 1'b0;
    pol_a = 1'b1;
  endtask
  task automatic t_count;
    int f, l, h;
    prep(1'b1, 8'h66, 8'h0C, 8'hFC, 8'hFC, 8'h50);
    prep(1'b0, 8'h66, 8'h0C, 8'hFC, 8'hFC, 8'h50);
    watch(2, 40, f, l, h);
    chk("no events", h, 0);
    ev_a <= 1'b1;
    ev_b <= 1'b1;
    for (int s = 2; s < 4; s++) begin
      watch(s, 60, f, l, h);
      chk("event period", l - f, (h - 1) * 16);
      chk("events counted", h != 0, 1);
    end
    ev_a <= 1'b0;
    ev_b <= 1'b0;
    wr(`DLCT_ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_prescale;
    int f, l, h;
    int per[5] = '{12, 4, 48, 32, 1};
    for (int k = 0; k < 5; k++) begin
      prep(1'b0, 8'h02, (k == 4) ? 8'h04 : k[7:0], 8'hFF, 8'hFF, 8'h10);
      watch(2, 200, f, l, h);
      chk("tick period", l - f, (h - 1) * per[k]);
      chk("ticks seen", h >= 4, 1);
      wr(`DLCT_ADDR_CONTROL, 8'h00);
    end
  endtask
  task automatic t_split;
    int f, l, h;
    b_ie = 1'b1;
    prep(1'b0, 8'h03, 8'h04, 8'hFE, 8'h00, 8'h40);
    watch(1, 10, f, l, h);
    chk("high byte flags b", h != 0, 1);
    rdchk("b flag bit", `DLCT_ADDR_CONTROL, 8'h80, 8'h80);
    b_ack = 1'b1;
    @(negedge sys_clk);
    b_ack = 1'b0;
    @(negedge sys_clk);
    chk("b irq acked", obs[1], 1'b0);
    rdchk("low byte idle", `DLCT_ADDR_A_LOW, 8'hFF, 8'h00);
    wr(`DLCT_ADDR_CONTROL, 8'h00);
    wr(`DLCT_ADDR_A_LOW, 8'hFE);
    wr(`DLCT_ADDR_CONTROL, 8'h10);
    watch(2, 10, f, l, h);
    chk("low byte runs", h != 0, 1);
    wr(`DLCT_ADDR_CONTROL, 8'h00);
    prep(1'b1, 8'h13, 8'h0C, 8'hFF, 8'hF0, 8'h00);
    watch(3, 40, f, l, h);
    chk("b pulse kept", h, 1);
    chk("b flag unset", obs[1], 1'b0);
    prep(1'b1, 8'h30, 8'h0C, 8'hFF, 8'hF0, 8'h00);
    watch(3, 40, f, l, h);
    chk("b inactive", h, 0);
    b_ie = 1'b0;
  endtask
  task automatic t_ticks;
    int f, l, h;
    int quiet[4] = '{8, 8, 3, 3};
    c_split = 1'b1;
    d_split = 1'b1;
    wr(`DLCT_ADDR_CLK_SEL, 8'hF0);
    for (int s = 4; s < 8; s++) begin
      watch(s, 10, f, l, h);
      chk("sys ticks", h, 10);
    end
    wr(`DLCT_ADDR_CLK_SEL, 8'h00);
    for (int s = 4; s < 8; s++) begin
      watch(s, 96, f, l, h);
      chk("source ticks", h, quiet[s - 4]);
    end
    c_split = 1'b0;
    wr(`DLCT_ADDR_CLK_SEL, 8'h20);
    watch(5, 96, f, l, h);
    chk("high select ignored", h, 8);
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_regs;
    t_wrap;
    t_reload;
    t_gate;
    t_count;
    t_prescale;
    t_split;
    t_ticks;
    give_verdict;
  end
  // the sequence needs some 2400 cycles; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
endmodule // dual_legacy_counter_timers_bench
`default_nettype wire
